// [design/npic_ctrl.sv]
/*
  Nested priority interrupt controller with its priority registers, the
  priority bits of the condition code, external line edge capture and the
  low power wake logic.
  Assumes a CPU sequencer that reports instruction ends and stacks context
  on request, and peripherals that present flag, enable and clear strobes.
*/
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Current priority lives in condition code bits five and three.
// - Codes 10, 01, 00, 11 mean levels zero, one, two, three.
// - Vectors sit between ffe0 and ffff, ordered by hardware priority.
// - Requests are taken only at an instruction end; the code also takes them on a wake from halt or wait, with no instruction end.
// - Maskable and trap entry ask the CPU to stack its context.
// - Maskable entry loads the vector's software level as current level.
// - The vector address goes to the sequencer to load into the PC.
// - Interrupt return restores the popped priority bits.
// - Highest software level wins, ties go to highest hardware priority.
// - Unserviced requests stay latched until they win.
// - Reset and trap ignore masking and leave level three set.
// - Only halt-capable maskable sources wake the core from halt.
// - The trap instruction raises the trap request.
// - Reset is the top source and starts at level three.
// - A maskable request needs a level strictly above the current one.
// - External edges latch and clear on service entry.
// - Selected pins of one line are ORed together.
// - Peripheral request needs both its flag and its enable.
// - The peripheral clear sequence drops a pending request.
// - Anything wakes from wait, only capable sources wake from halt.
// - Leaving halt, the first service is chosen among capable requests.
// - Priority instructions may change the current level.
// - Four priority registers reset to all ones.
// - Writing the level zero code leaves the field unchanged.
// - Unmask loads 10, mask loads 11.
module npic_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        instr_end_i,
  input  wire logic [2:0]  cpu_op_i,
  input  wire logic [7:0]  pop_cc_i,
  input  wire logic        flags_we_i,
  input  wire logic [3:0]  flags_i,
  input  wire logic [7:0]  ext_pin_i,
  input  wire logic [13:0] periph_flag_i,
  input  wire logic [13:0] periph_en_i,
  input  wire logic [13:0] periph_clr_i,
  output logic             take_o,
  output logic      [15:0] vector_o,
  output logic             stack_o,
  output logic      [7:0]  cc_o,
  output logic             wake_o
);
  logic [7:0]  isp [4];
  logic [7:0]  ext_sel;
  logic [13:0] pend;
  logic        trap_pend;
  logic        reset_pend;
  logic [7:0]  sync1;
  logic [7:0]  sync2;
  logic [7:0]  sync3;
  logic [7:0]  filt;
  logic [7:0]  next_filt;
  logic [7:0]  pin_rise;
  logic [3:0]  ext_line;
  logic [13:0] raise;
  logic [31:0] isp_flat;
  logic [13:0] cand;
  logic        found;
  logic [3:0]  best_v;
  logic [1:0]  best_l;
  logic        evaluate;
  logic        wake_now;
  logic        take_mask;
  logic        wb_req;
  npic_pkg::npic_state_t state;

  function automatic logic [1:0] rank(input logic [1:0] code);
    case (code)
      npic_pkg::LVL0: rank = 2'h0;
      npic_pkg::LVL1: rank = 2'h1;
      npic_pkg::LVL2: rank = 2'h2;
      default:        rank = 2'h3;
    endcase
  endfunction

  function automatic logic [15:0] vec_addr(input logic [3:0] v);
    vec_addr = npic_pkg::VEC_TOP - {11'h0, v, 1'b0};
  endfunction

  function automatic logic [7:0] isp_merge(input logic [7:0] old, input logic [7:0] nw);
    logic [7:0] m;
    m = nw;
    for (int f = 0; f < 4; f++) begin
      if (nw[2*f +: 2] == npic_pkg::LVL0) begin
        m[2*f +: 2] = old[2*f +: 2];
      end
    end
    isp_merge = m;
  endfunction

  function automatic logic [1:0] cur_code(input logic [7:0] cc);
    cur_code = {cc[npic_pkg::CC_I1], cc[npic_pkg::CC_I0]};
  endfunction

  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign isp_flat = {isp[3], isp[2], isp[1], isp[0]};

  // External pins pass three flip-flops and count once the last two agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
      filt  <= 8'h00;
    end else begin
      sync1 <= ext_pin_i;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= next_filt;
    end
  end

  always_comb begin
    next_filt = ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & filt);
    pin_rise  = next_filt & ~filt & ext_sel;
    for (int l = 0; l < 4; l++) begin
      ext_line[l] = |pin_rise[2*l +: 2];
    end
    raise = (periph_flag_i & periph_en_i & ~npic_pkg::EXT_MASK);
    raise[npic_pkg::EXT_FIRST +: 4] = ext_line;
  end

  // Arbitration: descending scan with >= lets the lower index win ties.
  always_comb begin
    found  = 1'b0;
    best_v = 4'h0;
    best_l = 2'h0;
    cand   = (state == npic_pkg::NPIC_HALT) ? (pend & npic_pkg::HALT_CAP) : pend;
    for (int v = npic_pkg::NPIC_NVEC - 1; v >= 0; v--) begin
      if (cand[v] && (!found || rank(isp_flat[2*v +: 2]) >= best_l)) begin
        found  = 1'b1;
        best_v = 4'(v);
        best_l = rank(isp_flat[2*v +: 2]);
      end
    end
  end

  always_comb begin
    case (state)
      npic_pkg::NPIC_WAIT: wake_now = (|pend) || trap_pend;
      npic_pkg::NPIC_HALT: wake_now = |(pend & npic_pkg::HALT_CAP);
      default:             wake_now = 1'b0;
    endcase
    evaluate  = wake_now || (state == npic_pkg::NPIC_RUN && instr_end_i &&
                             cpu_op_i == npic_pkg::OP_NOP);
    take_mask = evaluate && !reset_pend && !trap_pend && found &&
                best_l > rank(cur_code(cc_o));
  end

  // Pending latches; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= 14'h0000;
    end else begin
      for (int v = 0; v < npic_pkg::NPIC_NVEC; v++) begin
        if (raise[v]) begin
          pend[v] <= 1'b1;
        end else if (periph_clr_i[v] && !npic_pkg::EXT_MASK[v]) begin
          pend[v] <= 1'b0;
        end else if (take_mask && best_v == 4'(v) && npic_pkg::EXT_MASK[v]) begin
          pend[v] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_pend <= 1'b1;
      trap_pend  <= 1'b0;
    end else begin
      if (reset_pend) begin
        reset_pend <= 1'b0;
      end
      if (instr_end_i && cpu_op_i == npic_pkg::OP_TRAP) begin
        trap_pend <= 1'b1;
      end else if (evaluate && !reset_pend && trap_pend) begin
        trap_pend <= 1'b0;
      end
    end
  end

  // Sequencer strobe, vector and stacking request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      take_o   <= 1'b0;
      vector_o <= npic_pkg::VEC_RESET;
      stack_o  <= 1'b0;
    end else begin
      take_o  <= 1'b0;
      stack_o <= 1'b0;
      if (reset_pend) begin
        take_o   <= 1'b1;
        vector_o <= npic_pkg::VEC_RESET;
      end else if (evaluate && trap_pend) begin
        take_o   <= 1'b1;
        stack_o  <= 1'b1;
        vector_o <= npic_pkg::VEC_TRAP;
      end else if (take_mask) begin
        take_o   <= 1'b1;
        stack_o  <= 1'b1;
        vector_o <= vec_addr(best_v);
      end
    end
  end

  // Condition code with its priority bits.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cc_o <= npic_pkg::CC_RST;
    end else if (reset_pend || (evaluate && trap_pend)) begin
      cc_o[npic_pkg::CC_I1] <= 1'b1;
      cc_o[npic_pkg::CC_I0] <= 1'b1;
    end else if (take_mask) begin
      cc_o[npic_pkg::CC_I1] <= isp_flat[2*best_v + 1];
      cc_o[npic_pkg::CC_I0] <= isp_flat[2*best_v];
    end else if (instr_end_i) begin
      case (cpu_op_i)
        npic_pkg::OP_RIM, npic_pkg::OP_HALT, npic_pkg::OP_WFI: begin
          cc_o[npic_pkg::CC_I1] <= npic_pkg::LVL0[1];
          cc_o[npic_pkg::CC_I0] <= npic_pkg::LVL0[0];
        end
        npic_pkg::OP_SIM: begin
          cc_o[npic_pkg::CC_I1] <= npic_pkg::LVL3[1];
          cc_o[npic_pkg::CC_I0] <= npic_pkg::LVL3[0];
        end
        npic_pkg::OP_INTERRUPT_RETURN_INSTR, npic_pkg::OP_POPCC: begin
          cc_o <= {2'b11, pop_cc_i[5:0]};
        end
        default: begin
          if (flags_we_i) begin
            cc_o[4] <= flags_i[3];
            cc_o[2:0] <= flags_i[2:0];
          end
        end
      endcase
    end else if (flags_we_i) begin
      cc_o[4] <= flags_i[3];
      cc_o[2:0] <= flags_i[2:0];
    end
  end

  // Low power state and wake pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= npic_pkg::NPIC_RUN;
      wake_o <= 1'b0;
    end else begin
      wake_o <= wake_now;
      case (state)
        npic_pkg::NPIC_RUN: begin
          if (instr_end_i && cpu_op_i == npic_pkg::OP_HALT) begin
            state <= npic_pkg::NPIC_HALT;
          end else if (instr_end_i && cpu_op_i == npic_pkg::OP_WFI) begin
            state <= npic_pkg::NPIC_WAIT;
          end
        end
        default: begin
          if (wake_now) begin
            state <= npic_pkg::NPIC_RUN;
          end
        end
      endcase
    end
  end

  // Register bus slave: registered answer one cycle after the request, ack for one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int r = 0; r < 4; r++) begin
        isp[r] <= npic_pkg::ISP_RST;
      end
      ext_sel <= npic_pkg::EXTSEL_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == npic_pkg::ADR_ISP0) begin
        isp[0] <= isp_merge(isp[0], wb_dat_i[7:0]);
      end else if (wb_adr_i == npic_pkg::ADR_ISP1) begin
        isp[1] <= isp_merge(isp[1], wb_dat_i[7:0]);
      end else if (wb_adr_i == npic_pkg::ADR_ISP2) begin
        isp[2] <= isp_merge(isp[2], wb_dat_i[7:0]);
      end else if (wb_adr_i == npic_pkg::ADR_ISP3) begin
        isp[3] <= isp_merge(isp[3], wb_dat_i[7:0]) | npic_pkg::ISP3_RO;
      end else if (wb_adr_i == npic_pkg::ADR_EXTSEL) begin
        ext_sel <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == npic_pkg::ADR_ISP0) begin
          wb_dat_o <= {24'h0, isp[0]};
        end else if (wb_adr_i == npic_pkg::ADR_ISP1) begin
          wb_dat_o <= {24'h0, isp[1]};
        end else if (wb_adr_i == npic_pkg::ADR_ISP2) begin
          wb_dat_o <= {24'h0, isp[2]};
        end else if (wb_adr_i == npic_pkg::ADR_ISP3) begin
          wb_dat_o <= {24'h0, isp[3]};
        end else if (wb_adr_i == npic_pkg::ADR_CC) begin
          wb_dat_o <= {24'h0, cc_o};
        end else if (wb_adr_i == npic_pkg::ADR_EXTSEL) begin
          wb_dat_o <= {24'h0, ext_sel};
        end else if (wb_adr_i == npic_pkg::ADR_STAT) begin
          wb_dat_o <= {14'h0, state == npic_pkg::NPIC_HALT, state == npic_pkg::NPIC_WAIT,
                       1'b0, trap_pend, pend};
        end
      end
    end
  end

  // Helper: index of the vector just taken.
  logic [15:0] taken_off;
  logic [3:0]  taken_v;
  assign taken_off = npic_pkg::VEC_TOP - vector_o;
  assign taken_v   = taken_off[4:1];

  chk_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  chk_ack_next_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("bus request not answered");
  chk_cc_upper_ones: assert property (@(posedge clk_i) disable iff (rst_i)
    cc_o[7:6] == 2'b11) else $error("condition code upper bits not set");
  chk_vector_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
    take_o |-> vector_o >= npic_pkg::VEC_BOTTOM && !vector_o[0])
    else $error("vector outside table");
  chk_reset_vector_nostack: assert property (@(posedge clk_i)
    rst_i ##1 !rst_i |-> ##1 (take_o && vector_o == npic_pkg::VEC_RESET && !stack_o
    && cur_code(cc_o) == npic_pkg::LVL3)) else $error("reset entry wrong");
  chk_trap_level_three: assert property (@(posedge clk_i) disable iff (rst_i)
    take_o && vector_o == npic_pkg::VEC_TRAP |-> stack_o && cur_code(cc_o) == npic_pkg::LVL3)
    else $error("trap entry wrong");
  chk_mask_strictly_higher: assert property (@(posedge clk_i) disable iff (rst_i)
    take_o && vector_o <= npic_pkg::VEC_TOP |-> rank(cur_code(cc_o)) > rank(cur_code($past(cc_o))))
    else $error("maskable taken without higher level");
  chk_halt_capable_first: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(state == npic_pkg::NPIC_HALT) && take_o && vector_o <= npic_pkg::VEC_TOP
    |-> npic_pkg::HALT_CAP[taken_v]) else $error("halt exit by incapable source");
  chk_rim_loads_level0: assert property (@(posedge clk_i) disable iff (rst_i)
    instr_end_i && cpu_op_i == npic_pkg::OP_RIM |=> cur_code(cc_o) == npic_pkg::LVL0)
    else $error("unmask did not load level zero");
  chk_trap_serviced: assert property (@(posedge clk_i) disable iff (rst_i)
    evaluate && trap_pend && !reset_pend |=> take_o && stack_o && vector_o == npic_pkg::VEC_TRAP)
    else $error("trap not serviced at next end");

  cov_trap_taken: cover property (@(posedge clk_i) disable iff (rst_i)
    take_o && vector_o == npic_pkg::VEC_TRAP);
  cov_mask_taken: cover property (@(posedge clk_i) disable iff (rst_i)
    take_o && stack_o && vector_o <= npic_pkg::VEC_TOP);
  cov_halt_wake: cover property (@(posedge clk_i) disable iff (rst_i)
    state == npic_pkg::NPIC_HALT ##1 wake_o);
  cov_nested: cover property (@(posedge clk_i) disable iff (rst_i)
    take_o && cur_code(cc_o) != npic_pkg::LVL3 ##[1:50] take_o);
endmodule
`default_nettype wire

// [design/npic_pkg.sv]
/*
  Constants of the nested priority interrupt controller: register offsets,
  reset values, priority codes, vector addresses and sequencer operations.
  Assumes a 32-bit classic Wishbone register bus.
*/
package npic_pkg;
  localparam int          NPIC_NVEC  = 14;
  localparam logic [7:0]  ADR_ISP0   = 8'h00;
  localparam logic [7:0]  ADR_ISP1   = 8'h04;
  localparam logic [7:0]  ADR_ISP2   = 8'h08;
  localparam logic [7:0]  ADR_ISP3   = 8'h0c;
  localparam logic [7:0]  ADR_CC     = 8'h10;
  localparam logic [7:0]  ADR_EXTSEL = 8'h14;
  localparam logic [7:0]  ADR_STAT   = 8'h18;
  localparam logic [7:0]  ISP_RST    = 8'hff;
  localparam logic [7:0]  ISP3_RO    = 8'hf0;
  localparam logic [7:0]  CC_RST     = 8'hea;
  localparam logic [7:0]  EXTSEL_RST = 8'h00;
  localparam int          CC_I1      = 5;
  localparam int          CC_I0      = 3;
  localparam logic [1:0]  LVL0       = 2'b10;
  localparam logic [1:0]  LVL1       = 2'b01;
  localparam logic [1:0]  LVL2       = 2'b00;
  localparam logic [1:0]  LVL3       = 2'b11;
  localparam logic [15:0] VEC_RESET  = 16'hfffe;
  localparam logic [15:0] VEC_TRAP   = 16'hfffc;
  localparam logic [15:0] VEC_TOP    = 16'hfffa;
  localparam logic [15:0] VEC_BOTTOM = 16'hffe0;
  localparam logic [13:0] HALT_CAP   = 14'h00be;
  localparam logic [13:0] EXT_MASK   = 14'h003c;
  localparam int          EXT_FIRST  = 2;
  localparam logic [2:0]  OP_NOP     = 3'h0;
  localparam logic [2:0]  OP_RIM     = 3'h1;
  localparam logic [2:0]  OP_SIM     = 3'h2;
  localparam logic [2:0]  OP_HALT    = 3'h3;
  localparam logic [2:0]  OP_WFI     = 3'h4;
  localparam logic [2:0]  OP_INTERRUPT_RETURN_INSTR    = 3'h5;
  localparam logic [2:0]  OP_POPCC   = 3'h6;
  localparam logic [2:0]  OP_TRAP    = 3'h7;
  typedef enum logic [1:0] {NPIC_RUN, NPIC_WAIT, NPIC_HALT} npic_state_t;
endpackage

// [tb/npic_cpu_model.sv]
/*
  Behavioural CPU sequencer facing the interrupt controller: it ends an
  instruction every GAP cycles, stalls while stacking, sleeps after halt or wait.
  Assumes the controller's take, stack and wake outputs as its inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module npic_cpu_model #(
  parameter int GAP = 3
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       take_i,
  input  wire logic       stack_i,
  input  wire logic       wake_i,
  output logic            instr_end_o,
  output logic      [2:0] cpu_op_o
);
  logic       req;
  logic [2:0] req_op;
  logic       asleep;
  int         busy;
  initial begin
    req = 1'b0;
    req_op = 3'h0;
    instr_end_o = 1'b0;
    cpu_op_o = 3'h0;
  end
  // Ends the next instruction with the given operation.
  task automatic exec(input logic [2:0] op);
    req_op <= op;
    req <= 1'b1;
    @(posedge clk_i);
    while (req) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    instr_end_o <= 1'b0;
    cpu_op_o <= 3'h0;
    if (rst_i) begin
      asleep <= 1'b0;
      busy <= 0;
    end else if (take_i) begin
      busy <= stack_i ? 5 : 2;
      asleep <= 1'b0;
    end else if (wake_i) begin
      asleep <= 1'b0;
    end else if (busy > 0) begin
      busy <= busy - 1;
    end else if (!asleep) begin
      busy <= GAP - 1;
      instr_end_o <= 1'b1;
      if (req) begin
        cpu_op_o <= req_op;
        req <= 1'b0;
        asleep <= (req_op == npic_pkg::OP_HALT) || (req_op == npic_pkg::OP_WFI);
      end
    end
  end
endmodule
`default_nettype wire

// [tb/npic_ctrl_test.sv]
/*
  Self-checking bench of the interrupt controller: registers, arbitration,
  nesting, trap, external edges, clear sequence and halt wake.
  Assumes the CPU model in npic_cpu_model.sv.
*/
`timescale 1ns/1ps
`default_nettype none
module npic_ctrl_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dout;
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  pins = 8'h00;
  logic [7:0]  pop_cc = 8'he2;
  logic [13:0] flag = 14'h0;
  logic [13:0] en = 14'h0;
  logic [13:0] clr = 14'h0;
  logic [3:0]  sel = 4'hf;
  logic        fwe = 1'b0;
  logic [3:0]  fl = 4'h0;
  logic        iend;
  logic        take;
  logic        stk;
  logic        wake;
  logic [2:0]  op;
  logic [15:0] vec;
  logic [7:0]  cc;
  logic [15:0] t_vec;
  logic        t_stk;
  logic [7:0]  t_cc;
  int          err_count = 0;
  int          compares = 0;
  int          n_take = 0;
  int          n_wake = 0;
  int          seen = 0;
  always #10 clk = ~clk;
  npic_ctrl dut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .instr_end_i(iend), .cpu_op_i(op), .pop_cc_i(pop_cc), .flags_we_i(fwe),
    .flags_i(fl), .ext_pin_i(pins), .periph_flag_i(flag), .periph_en_i(en),
    .periph_clr_i(clr), .take_o(take), .vector_o(vec), .stack_o(stk), .cc_o(cc),
    .wake_o(wake)
  );
  npic_cpu_model #(.GAP(3)) cpu (
    .clk_i(clk), .rst_i(rst), .take_i(take), .stack_i(stk), .wake_i(wake),
    .instr_end_o(iend), .cpu_op_o(op)
  );
  always @(posedge clk) begin
    n_wake += (wake === 1'b1);
    if (take === 1'b1) begin
      n_take++;
      t_vec = vec;
      t_stk = stk;
      t_cc = cc;
    end
  end
  function automatic logic [7:0] cc_of(input logic [1:0] l);
    return {2'b11, l[1], 1'b0, l[0], 3'b010};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    rdat = dout;
    check({31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rdat, e);
  endtask
  task automatic op_cc(input logic [2:0] o, input logic [1:0] l);
    cpu.exec(o);
    repeat (2) @(posedge clk);
    check({24'h0, cc}, {24'h0, cc_of(l)});
  endtask
  task automatic expect_take(input logic [15:0] v, input logic s, input logic [1:0] l);
    logic hit;
    for (int i = 0; i < 200 && n_take == seen; i++) @(posedge clk);
    hit = (n_take != seen);
    seen = n_take;
    check({t_vec, 6'h0, hit, t_stk, t_cc}, {v, 6'h0, 1'b1, s, cc_of(l)});
  endtask
  task automatic expect_none(input int n);
    repeat (n) @(posedge clk);
    check(n_take - seen, 32'h0);
  endtask
  task automatic drop(input int v);
    flag[v] <= 1'b0;
    clr <= 14'h1 << v;
    @(posedge clk);
    clr <= 14'h0;
    @(posedge clk);
  endtask
  task automatic finish_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    expect_take(16'hfffe, 1'b0, 2'b11);
    for (int a = 0; a < 16; a += 4) rd_chk(8'(a), 32'hff);
    rd_chk(8'h10, 32'hea);
    rd_chk(8'h40, 32'h0);
    xfer(1'b1, 8'h00, 32'hcf);
    xfer(1'b1, 8'h00, 32'h64);
    rd_chk(8'h00, 32'h44);
    sel <= 4'h0;
    xfer(1'b1, 8'h0c, 32'h0);
    sel <= 4'hf;
    rd_chk(8'h0c, 32'hff);
    xfer(1'b1, 8'h0c, 32'h0);
    rd_chk(8'h0c, 32'hf0);
    op_cc(3'h1, 2'b10);
    op_cc(3'h2, 2'b11);
    xfer(1'b1, 8'h08, 32'hc5);
    flag <= 14'h300;
    en <= 14'h700;
    expect_none(10);
    rd_chk(8'h18, 32'h300);
    cpu.exec(3'h1);
    expect_take(16'hffea, 1'b1, 2'b01);
    drop(8);
    expect_none(10);
    flag[10] <= 1'b1;
    expect_take(16'hffe6, 1'b1, 2'b00);
    drop(10);
    drop(9);
    rd_chk(8'h18, 32'h0);
    op_cc(3'h5, 2'b10);
    expect_none(10);
    op_cc(3'h2, 2'b11);
    cpu.exec(3'h7);
    expect_take(16'hfffc, 1'b1, 2'b11);
    op_cc(3'h5, 2'b10);
    xfer(1'b1, 8'h14, 32'h03);
    pins <= 8'h02;
    expect_take(16'hfff6, 1'b1, 2'b00);
    rd_chk(8'h18, 32'h0);
    pins <= 8'h00;
    op_cc(3'h5, 2'b10);
    pins <= 8'h01;
    expect_take(16'hfff6, 1'b1, 2'b00);
    pins <= 8'h00;
    op_cc(3'h5, 2'b10);
    xfer(1'b1, 8'h08, 32'hc1);
    cpu.exec(3'h3);
    flag[9] <= 1'b1;
    expect_none(10);
    flag[1] <= 1'b1;
    en[1] <= 1'b1;
    expect_take(16'hfff8, 1'b1, 2'b01);
    expect_take(16'hffe8, 1'b1, 2'b00);
    check(n_wake, 32'h1);
    drop(9);
    drop(1);
    cpu.exec(3'h4);
    flag[10] <= 1'b1;
    expect_take(16'hffe6, 1'b1, 2'b00);
    check(n_wake, 32'h2);
    pop_cc <= 8'h2a;
    op_cc(3'h6, 2'b11);
    fl <= 4'hd;
    fwe <= 1'b1;
    @(posedge clk);
    fwe <= 1'b0;
    rd_chk(8'h10, 32'hfd);
    finish_test;
  end
endmodule
`default_nettype wire
